// file: design/wdc_pkg.sv
package wdc_pkg;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned LF_HZ     = 32768;

  // byte offsets
  localparam logic [ADDR_W-1:0] OFF_RELOAD    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_COUNT     = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CONTROL   = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_KEY       = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_KEY_ALIAS = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 12'h018;

  // reset values and constants
  localparam logic [15:0] LOAD_RST    = 16'h0400;
  localparam logic [15:0] COUNT_RST   = 16'h1000;
  localparam logic [15:0] FIXED_TOP   = 16'h1000;
  localparam logic [7:0]  CTRL_RST    = 8'he9;
  localparam logic [7:0]  CTRL_WMASK  = 8'h6f;
  localparam logic [15:0] SERVICE_KEY = 16'hcccc;

  // control field positions
  localparam int unsigned CTL_HOLD = 0;
  localparam int unsigned CTL_IRQ  = 1;
  localparam int unsigned CTL_PRE  = 2;
  localparam int unsigned CTL_EN   = 5;
  localparam int unsigned CTL_MODE = 6;

  // status field positions
  localparam int unsigned ST_IRQ  = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_EN   = 5;

  typedef enum logic [2:0] {
    WDC_OPEN     = 3'b001,
    WDC_DISABLED = 3'b010,
    WDC_LOCKED   = 3'b100
  } wdc_lock_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } wdc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } wdc_apb_rsp_t;

  // prescaler terminal count per code
  function automatic logic [11:0] wdc_pre_tc(input logic [1:0] code);
    case (code)
      2'b00:   wdc_pre_tc = 12'h000;
      2'b01:   wdc_pre_tc = 12'h00f;
      2'b10:   wdc_pre_tc = 12'h0ff;
      default: wdc_pre_tc = 12'hfff;
    endcase
  endfunction
endpackage

// file: design/wdc_watchdog.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wdc_watchdog
  import wdc_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // apb slave
  input  wire wdc_apb_req_t apb_req,
  output var  wdc_apb_rsp_t apb_rsp,
  // oscillator tick and core status
  input  wire logic         lfosc_tick,
  input  wire logic         cpu_halted,
  // timeout actions
  output logic              wdog_irq,
  output logic              wdog_reset_pulse
);

  typedef struct packed {
    wdc_lock_t         lock;
    logic [CNT_W-1:0]  count;
    logic [11:0]       presc;
    logic [CNT_W-1:0]  load;
    logic [7:0]        ctrl;
    logic              key_pend;
    logic [15:0]       key_val;
    logic              ctl_pend;
    logic [7:0]        ctl_val;
    logic              load_pend;
    logic [CNT_W-1:0]  load_val;
    logic              irq;
    logic              reset_pulse;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } wdc_state_t;

  wdc_state_t s;
  wdc_state_t n;

  logic run;
  logic dec_tick;
  logic timeout;
  logic key_good;
  logic key_bad;
  logic ctl_apply;
  logic load_apply;
  logic wr_done;
  logic addr_ok;
  logic [7:0] ctl_new;
  logic [CNT_W-1:0] top;

  // next state: bus side, oscillator-paced apply, counter
  always_comb begin
    n           = s;
    run         = 1'b0;
    dec_tick    = 1'b0;
    timeout     = 1'b0;
    key_good    = 1'b0;
    key_bad     = 1'b0;
    ctl_apply   = 1'b0;
    load_apply  = 1'b0;
    ctl_new     = s.ctrl;
    top         = s.ctrl[CTL_MODE] ? s.load : FIXED_TOP;
    n.reset_pulse = 1'b0;

    // one wait state: answer in the second access cycle
    n.pready  = apb_req.psel & apb_req.penable & ~s.pready;
    wr_done   = apb_req.psel & apb_req.penable & s.pready & apb_req.pwrite;
    case (apb_req.paddr)
      OFF_RELOAD, OFF_COUNT, OFF_CONTROL,
      OFF_KEY, OFF_KEY_ALIAS, OFF_STATUS: addr_ok = 1'b1;
      default:                             addr_ok = 1'b0;
    endcase
    n.pslverr = n.pready & ~addr_ok;
    n.prdata  = 32'h0000_0000;
    if (n.pready && !apb_req.pwrite) begin
      case (apb_req.paddr)
        OFF_RELOAD:  n.prdata = {16'h0000, s.load};
        OFF_COUNT:   n.prdata = {16'h0000, s.count};
        OFF_CONTROL: n.prdata = {24'h00_0000, s.ctrl};
        OFF_STATUS: begin
          n.prdata[ST_IRQ]  = s.irq;
          n.prdata[ST_BUSY] = s.key_pend | s.ctl_pend | s.load_pend;
          n.prdata[ST_EN]   = s.ctrl[CTL_EN];
        end
        default:     n.prdata = 32'h0000_0000; // key reads as zero
      endcase
    end

    // counting only moves on oscillator ticks; cpu_halted gates it when hold is set
    if (lfosc_tick) begin
      run = s.ctrl[CTL_EN] & ~(s.ctrl[CTL_HOLD] & cpu_halted);
      if (run) begin
        if (s.presc == wdc_pre_tc(s.ctrl[CTL_PRE+1:CTL_PRE])) begin
          n.presc  = 12'h000;
          dec_tick = 1'b1;
        end else begin
          n.presc = s.presc + 12'h001;
        end
      end
      // period is divider times (top + 1): top ticks to zero, one to wrap
      if (dec_tick) begin
        if (s.count == 16'h0000) begin
          n.count = top;
        end else begin
          n.count = s.count - 16'h0001;
          timeout = (s.count == 16'h0001);
        end
      end

      // queued bus writes act only here, paced by the oscillator
      if (s.key_pend) begin
        key_good = (s.key_val == SERVICE_KEY);
        key_bad  = ~key_good;
      end
      if (key_good) begin
        n.count = top;
        n.presc = 12'h000;
        n.irq   = 1'b0;
      end
      if (key_bad) begin
        timeout = 1'b1;
      end
      n.key_pend = 1'b0;

      // control write, gated by the lock sequence
      ctl_apply = s.ctl_pend & (s.lock != WDC_LOCKED);
      if (ctl_apply) begin
        ctl_new = (s.ctrl & ~CTRL_WMASK) | (s.ctl_val & CTRL_WMASK);
        n.ctrl  = ctl_new;
        n.presc = 12'h000;
        n.count = ctl_new[CTL_MODE] ? s.load : FIXED_TOP;
        if (!ctl_new[CTL_EN]) begin
          n.lock = WDC_DISABLED;
        end else begin
          n.lock = WDC_LOCKED;
        end
      end
      n.ctl_pend = 1'b0;

      // reload write; periodic mode takes it into the counter at once
      load_apply = s.load_pend & (s.lock != WDC_LOCKED);
      if (load_apply) begin
        n.load = s.load_val;
        if (ctl_new[CTL_MODE]) begin
          n.count = s.load_val;
        end
      end
      n.load_pend = 1'b0;
    end

    // timeout action; a set beats the key clear in the same tick
    if (timeout) begin
      if (s.ctrl[CTL_IRQ]) begin
        n.irq = 1'b1;
      end else begin
        n.reset_pulse = 1'b1;
      end
    end

    // capture bus writes after apply, so a write in an apply cycle is kept
    if (wr_done && addr_ok) begin
      case (apb_req.paddr)
        OFF_RELOAD: begin
          n.load_pend = 1'b1;
          n.load_val  = apb_req.pwdata[15:0];
        end
        OFF_CONTROL: begin
          n.ctl_pend = 1'b1;
          n.ctl_val  = apb_req.pwdata[7:0];
        end
        OFF_KEY, OFF_KEY_ALIAS: begin
          n.key_pend = 1'b1;
          n.key_val  = apb_req.pwdata[15:0];
        end
        default: begin
          n.key_pend = n.key_pend; // read-only targets ignore writes
        end
      endcase
    end
  end

  // state register; power-on values start the counter enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s.lock        <= WDC_OPEN;
      s.count       <= COUNT_RST;
      s.presc       <= 12'h000;
      s.load        <= LOAD_RST;
      s.ctrl        <= CTRL_RST;
      s.key_pend    <= 1'b0;
      s.key_val     <= 16'h0000;
      s.ctl_pend    <= 1'b0;
      s.ctl_val     <= 8'h00;
      s.load_pend   <= 1'b0;
      s.load_val    <= 16'h0000;
      s.irq         <= 1'b0;
      s.reset_pulse <= 1'b0;
      s.pready      <= 1'b0;
      s.pslverr     <= 1'b0;
      s.prdata      <= 32'h0000_0000;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign apb_rsp.prdata   = s.prdata;
  assign apb_rsp.pready   = s.pready;
  assign apb_rsp.pslverr  = s.pslverr;
  assign wdog_irq         = s.irq;
  assign wdog_reset_pulse = s.reset_pulse;

  // checks
  AST_PRESC: assert property (@(posedge clk) disable iff (rst)
    dec_tick |-> lfosc_tick && s.ctrl[CTL_EN]
      && s.presc == wdc_pre_tc(s.ctrl[CTL_PRE+1:CTL_PRE]))
    else $error("decrement without prescaler terminal count");

  AST_RST_VAL: assert property (@(posedge clk)
    $past(rst) && !rst |-> s.load == LOAD_RST && s.ctrl[CTL_EN]
      && s.count == COUNT_RST)
    else $error("wrong power-on values");

  AST_FIXED_WRAP: assert property (@(posedge clk) disable iff (rst)
    dec_tick && s.count == 16'h0000 && !s.ctrl[CTL_MODE]
      && !s.key_pend && !s.ctl_pend && !s.load_pend
      |=> s.count == FIXED_TOP)
    else $error("fixed mode did not wrap to top");

  AST_PERIODIC: assert property (@(posedge clk) disable iff (rst)
    dec_tick && s.count == 16'h0000 && s.ctrl[CTL_MODE]
      && !s.key_pend && !s.ctl_pend && !s.load_pend
      |=> s.count == $past(s.load))
    else $error("periodic mode did not reload");

  AST_TO_IRQ: assert property (@(posedge clk) disable iff (rst)
    timeout && s.ctrl[CTL_IRQ] |=> s.irq && !s.reset_pulse)
    else $error("timeout did not raise interrupt");

  AST_TO_RST: assert property (@(posedge clk) disable iff (rst)
    timeout && !s.ctrl[CTL_IRQ] |=> s.reset_pulse ##1 !s.reset_pulse)
    else $error("timeout did not pulse reset");

  AST_KEY_OK: assert property (@(posedge clk) disable iff (rst)
    lfosc_tick && s.key_pend && s.key_val == SERVICE_KEY
      && !s.ctl_pend && !s.load_pend && !timeout
      |=> s.count == $past(top) && !s.irq)
    else $error("service key did not reload");

  AST_KEY_BAD: assert property (@(posedge clk) disable iff (rst)
    lfosc_tick && s.key_pend && s.key_val != SERVICE_KEY
      |=> s.irq || s.reset_pulse)
    else $error("wrong key did not fire timeout");

  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    s.ctrl[CTL_HOLD] && cpu_halted && !s.key_pend && !s.ctl_pend
      && !s.load_pend |=> $stable(s.count))
    else $error("count moved while halted with hold");

  AST_LOCKED: assert property (@(posedge clk) disable iff (rst)
    s.lock == WDC_LOCKED |=> $stable(s.ctrl) && $stable(s.load)
      && s.lock == WDC_LOCKED)
    else $error("locked settings changed");

  // checked on every cycle while disabled with no write pending, not just after the write
  AST_DISABLE: assert property (@(posedge clk) disable iff (rst)
    !s.ctrl[CTL_EN] && !s.key_pend && !s.ctl_pend && !s.load_pend
      |=> $stable(s.count) && s.lock == WDC_DISABLED)
    else $error("disabled counter moved");

  AST_RESTART: assert property (@(posedge clk) disable iff (rst)
    ctl_apply && ctl_new[CTL_EN] && !s.load_pend
      |=> s.lock == WDC_LOCKED && s.presc == 12'h000)
    else $error("enable write did not restart");

  AST_LOAD_NOW: assert property (@(posedge clk) disable iff (rst)
    load_apply && ctl_new[CTL_MODE] |=> s.count == $past(s.load_val))
    else $error("periodic reload write not taken");

  AST_SYNC: assert property (@(posedge clk) disable iff (rst)
    !$stable(s.ctrl) || !$stable(s.load) |-> $past(lfosc_tick))
    else $error("settings changed off oscillator tick");

  // only a good key on a tick may drop a pending interrupt
  AST_IRQ_HOLD: assert property (@(posedge clk) disable iff (rst)
    s.irq && !(lfosc_tick && s.key_pend && s.key_val == SERVICE_KEY) |=> s.irq)
    else $error("interrupt dropped without service key");

  AST_TICK_ONLY: assert property (@(posedge clk) disable iff (rst)
    !lfosc_tick |=> $stable(s.count) && $stable(s.presc))
    else $error("counter moved off oscillator tick");

  AST_APB_WAIT: assert property (@(posedge clk) disable iff (rst)
    apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable
      |-> !s.pready ##1 s.pready)
    else $error("answer not one wait state");

  // main scenarios
  COV_SERVICE: cover property (@(posedge clk) disable iff (rst) key_good);
  COV_BAD_KEY: cover property (@(posedge clk) disable iff (rst) key_bad);
  COV_TIMEOUT: cover property (@(posedge clk) disable iff (rst)
    dec_tick && s.count == 16'h0001);
  COV_LOCK:    cover property (@(posedge clk) disable iff (rst)
    s.lock == WDC_DISABLED ##[1:1000] s.lock == WDC_LOCKED);

endmodule
`default_nettype wire

// file: testbench/wdc_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module testbench
  import wdc_pkg::*;
;
  // clock, reset and stimulus
  logic         clk;
  logic         rst;
  wdc_apb_req_t req;
  wdc_apb_rsp_t rsp;
  logic         lfosc_tick;
  logic         cpu_halted;
  logic         wdog_irq;
  logic         wdog_reset_pulse;
  int           fails;
  int           compares;
  int           rst_pulses;

  wdc_watchdog u_dut (
    .clk              (clk),
    .rst              (rst),
    .apb_req          (req),
    .apb_rsp          (rsp),
    .lfosc_tick       (lfosc_tick),
    .cpu_halted       (cpu_halted),
    .wdog_irq         (wdog_irq),
    .wdog_reset_pulse (wdog_reset_pulse)
  );

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // reset request is a one-cycle pulse, so count it every edge
  always @(posedge clk) begin
    if (wdog_reset_pulse === 1'b1) rst_pulses++;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; only the watchdog process bounds the wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    `CHECK("pready wait", 2, n)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic chk_reg(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    `CHECK(nm, e, rd)
  endtask

  // oscillator ticks spaced apart, then let the effects land
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      lfosc_tick <= 1'b1;
      @(posedge clk);
      lfosc_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    #1;
  endtask

  task automatic power_cycle();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask

  function automatic logic [31:0] ctl_rb(input logic [7:0] v);
    return {24'h0, (CTRL_RST & ~CTRL_WMASK) | (v & CTRL_WMASK)};
  endfunction

  task automatic t_reset_values();
    logic [31:0] rd;
    logic        err;
    chk_reg(OFF_RELOAD, {16'h0, LOAD_RST}, "reload");
    chk_reg(OFF_COUNT, {16'h0, COUNT_RST}, "count");
    chk_reg(OFF_CONTROL, {24'h0, CTRL_RST}, "control");
    chk_reg(OFF_STATUS, 32'h1 << ST_EN, "status");
    chk_reg(OFF_KEY, 32'h0, "key read");
    apb(1'b0, 12'h020, 32'h0, rd, err);
    `CHECK("unmapped err", 1'b1, err)
    $display("test reset_values done");
  endtask

  // open state: wrong key fires reset, reload write loads at once
  task automatic t_keys_open();
    wr(OFF_KEY, 32'h1234);
    tick(1);
    `CHECK("reset pulses", 1, rst_pulses)
    `CHECK("irq", 1'b0, wdog_irq)
    wr(OFF_RELOAD, 32'h0007);
    tick(1);
    chk_reg(OFF_COUNT, 32'h0007, "count after reload");
    tick(254);
    chk_reg(OFF_COUNT, 32'h0006, "count after 256 ticks");
    wr(OFF_KEY_ALIAS, {16'h0, SERVICE_KEY});
    tick(1);
    chk_reg(OFF_COUNT, 32'h0007, "count after key");
    $display("test keys_open done");
  endtask

  // disable, reconfigure, relock, then time out in interrupt mode
  task automatic t_lock_irq();
    wr(OFF_CONTROL, 32'h00);
    tick(1);
    chk_reg(OFF_CONTROL, ctl_rb(8'h00), "control off");
    chk_reg(OFF_COUNT, {16'h0, FIXED_TOP}, "count off");
    tick(3);
    chk_reg(OFF_COUNT, {16'h0, FIXED_TOP}, "count stopped");
    wr(OFF_RELOAD, 32'h0005);
    wr(OFF_CONTROL, 32'h62);
    tick(1);
    chk_reg(OFF_COUNT, 32'h0005, "restart count");
    tick(4);
    `CHECK("irq early", 1'b0, wdog_irq)
    tick(1);
    `CHECK("irq timeout", 1'b1, wdog_irq)
    `CHECK("no reset in irq mode", 1, rst_pulses)
    chk_reg(OFF_STATUS, (32'h1 << ST_EN) | 32'h1, "status irq");
    wr(OFF_CONTROL, 32'h00);
    tick(1);
    wr(OFF_RELOAD, 32'h0010);
    tick(1);
    chk_reg(OFF_CONTROL, ctl_rb(8'h62), "control locked");
    chk_reg(OFF_RELOAD, 32'h0005, "reload locked");
    wr(OFF_KEY, {16'h0, SERVICE_KEY});
    tick(1);
    `CHECK("irq cleared", 1'b0, wdog_irq)
    chk_reg(OFF_COUNT, 32'h0005, "count reloaded");
    tick(3);
    `CHECK("irq before wrong key", 1'b0, wdog_irq)
    wr(OFF_KEY, 32'h0000);
    tick(1);
    `CHECK("irq wrong key", 1'b1, wdog_irq)
    `CHECK("no reset on wrong key", 1, rst_pulses)
    $display("test lock_irq done");
  endtask

  // fixed mode, divide by 16, halt hold
  task automatic t_fixed_hold();
    power_cycle();
    wr(OFF_CONTROL, 32'h00);
    tick(1);
    wr(OFF_CONTROL, 32'h27);
    tick(1);
    chk_reg(OFF_COUNT, {16'h0, FIXED_TOP}, "fixed top");
    tick(15);
    chk_reg(OFF_COUNT, {16'h0, FIXED_TOP}, "presc 15");
    tick(1);
    chk_reg(OFF_COUNT, {16'h0, FIXED_TOP} - 32'h1, "presc 16");
    cpu_halted <= 1'b1;
    tick(20);
    chk_reg(OFF_COUNT, {16'h0, FIXED_TOP} - 32'h1, "held count");
    cpu_halted <= 1'b0;
    tick(16);
    chk_reg(OFF_COUNT, {16'h0, FIXED_TOP} - 32'h2, "resumed count");
    $display("test fixed_hold done");
  endtask

  // bounded run time
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("unexpected run time expected done seen timeout");
    summarize();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    lfosc_tick = 1'b0;
    cpu_halted = 1'b0;
    fails = 0;
    compares = 0;
    rst_pulses = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_keys_open();
    t_lock_irq();
    t_fixed_hold();
    summarize();
  end
endmodule
`default_nettype wire
